// ==== core/esave_pkg.sv ====
// constants shared by the dc bus energy saving controller
// Contract
// - energy saving stops holding dc bus voltage
// - run held back while bus recharges
// - enter saving after programmed stop delay
// - nonzero delay at power-on enters saving
// - disabled delay never enters through delay
// - input rise enters saving when stopped, idle
// - input fall returns to normal operation
// - selector maps input: none, pin, command bit
// - run delayed until exit condition or timeout (code holds run until bus ready, also after timeout)
// - timeout still saving raises exit error
// - exit timeout 1 to 999 s, default 5
package esave_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned ONE_SEC_NS     = 1_000_000_000;
    localparam int unsigned CYCLES_PER_SEC = ONE_SEC_NS / CLK_PERIOD_NS;
    localparam int unsigned RECHARGE_NOM_S = 1;        // typical bus recharge time

    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    localparam int unsigned ENTRY_W = 15;
    localparam int unsigned EXIT_W  = 10;
    localparam logic [ENTRY_W-1:0] ENTRY_DELAY_MAX      = 15'h7e90; // 32400 s
    localparam logic [ENTRY_W-1:0] ENTRY_DELAY_DISABLED = 15'h0000; // also reset default
    localparam logic [EXIT_W-1:0]  EXIT_TIMEOUT_MIN     = 10'h001;  // 1 s
    localparam logic [EXIT_W-1:0]  EXIT_TIMEOUT_MAX     = 10'h3e7;  // 999 s
    localparam logic [EXIT_W-1:0]  EXIT_TIMEOUT_DEFAULT = 10'h005;  // 5 s

    // ------------------------------------------------------------
    // input selector
    // ------------------------------------------------------------
    localparam int unsigned SRC_W     = 3;
    localparam int unsigned BIT_W     = 4;
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned CMD_WORDS = 5;
    localparam logic [SRC_W-1:0] SRC_NONE    = 3'h0;
    localparam logic [SRC_W-1:0] SRC_DIGITAL = 3'h1;
    localparam logic [SRC_W-1:0] SRC_CMD0    = 3'h2;   // command words follow

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_SAVING,
        ST_RECHARGE
    } esave_state_e;

endpackage

// ==== core/sec_timer.sv ====
// seconds counter with prescaler, clears on demand and flags the limit
`timescale 1ns/1ps
`default_nettype none
module sec_timer #(
    parameter int unsigned CYCLES_PER_SEC = 100_000_000,
    parameter int unsigned COUNT_W        = 15
) (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_clear,
    input  wire logic [COUNT_W-1:0] i_limit,
    output var  logic               o_done
);
    localparam int unsigned PRE_W = $clog2(CYCLES_PER_SEC);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_SEC - 1);

    logic [PRE_W-1:0]   pre_cnt;
    logic [COUNT_W-1:0] sec_cnt;
    logic               sec_tick;

    assign sec_tick = (pre_cnt == PRE_LAST);

    // prescaler and seconds, frozen once the limit is met
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_cnt <= '0;
            sec_cnt <= '0;
            o_done  <= 1'b0;
        end else if (i_clear) begin
            pre_cnt <= '0;
            sec_cnt <= '0;
            o_done  <= 1'b0;
        end else if (!o_done) begin
            pre_cnt <= sec_tick ? '0 : pre_cnt + 1'b1;
            if (sec_tick) begin
                sec_cnt <= sec_cnt + 1'b1;
                o_done  <= (sec_cnt + 1'b1 >= i_limit);
            end
        end
    end
endmodule // sec_timer
`default_nettype wire

// ==== core/dc_bus_energy_saving_ctrl.sv ====
// stop-and-go energy saving controller for the drive dc bus
`timescale 1ns/1ps
`default_nettype none
module dc_bus_energy_saving_ctrl
    import esave_pkg::*;
#(
    parameter int unsigned DI_COUNT       = 16,
    parameter int unsigned CYCLES_PER_SEC = esave_pkg::CYCLES_PER_SEC
) (
    input  wire logic                                        i_core_clk,
    input  wire logic                                        i_rst_n,
    input  wire logic                                        i_motor_stopped,
    input  wire logic                                        i_run_cmd,
    input  wire logic                                        i_bus_ready,
    input  wire logic [esave_pkg::ENTRY_W-1:0]               i_entry_delay_setting,
    input  wire logic [esave_pkg::EXIT_W-1:0]                i_exit_timeout_setting,
    input  wire logic [esave_pkg::SRC_W-1:0]                 i_esave_src,
    input  wire logic [esave_pkg::BIT_W-1:0]                 i_esave_bit,
    input  wire logic [DI_COUNT-1:0]                         i_dig_in,
    input  wire logic [esave_pkg::CMD_WORDS*esave_pkg::WORD_W-1:0] i_cmd_words,
    input  wire logic                                        i_error_ack,
    output var  logic                                        o_bus_hold,
    output var  logic                                        o_esave_active,
    output logic                                             o_run_enable,
    output var  logic                                        o_exit_error
);
    import esave_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    esave_state_e       state;
    esave_state_e       next_state;
    logic [DI_COUNT-1:0] di_meta;
    logic [DI_COUNT-1:0] di_sync;
    logic               sel_level;
    logic               sel_prev;
    logic               sel_rise;
    logic               sel_fall;
    logic               pwr_init;
    logic               entry_enabled;
    logic               entry_clear;
    logic               entry_done;
    logic               exit_armed;
    logic               exit_done;
    logic [EXIT_W-1:0]  exit_limit;
    logic [CMD_WORDS-1:0] cmd_bit;

    // ------------------------------------------------------------
    // input selection
    // ------------------------------------------------------------

    // two-stage synchroniser for the digital input pins
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            di_meta <= '0;
            di_sync <= '0;
        end else begin
            di_meta <= i_dig_in;
            di_sync <= di_meta;
        end
    end

    // pick the addressed bit of each command word
    generate
        for (genvar w = 0; w < CMD_WORDS; w++) begin : g_cmd
            assign cmd_bit[w] = i_cmd_words[w*WORD_W + int'(i_esave_bit)];
        end
    endgenerate

    // source selector: none, pin, or command word bit
    always_comb begin
        sel_level = 1'b0;
        if (i_esave_src == SRC_DIGITAL) begin
            if (int'(i_esave_bit) < DI_COUNT) begin
                sel_level = di_sync[i_esave_bit];
            end
        end else if (i_esave_src >= SRC_CMD0 && i_esave_src < SRC_CMD0 + SRC_W'(CMD_WORDS)) begin
            sel_level = cmd_bit[i_esave_src - SRC_CMD0];
        end
    end

    // edge detector on the selected level
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_level;
        end
    end

    assign sel_rise = sel_level & ~sel_prev;
    assign sel_fall = ~sel_level & sel_prev;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------

    // delay path only while stopped, idle and enabled
    assign entry_enabled = (i_entry_delay_setting != ENTRY_DELAY_DISABLED);
    assign entry_clear   = !(state == ST_NORMAL && i_motor_stopped && !i_run_cmd
                             && entry_enabled);

    sec_timer #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC),
        .COUNT_W        (ENTRY_W)
    ) u_entry_timer (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_clear    (entry_clear),
        .i_limit    (i_entry_delay_setting),
        .o_done     (entry_done)
    );

    // exit timeout clamped into its legal range
    always_comb begin
        exit_limit = i_exit_timeout_setting;
        if (i_exit_timeout_setting < EXIT_TIMEOUT_MIN) begin
            exit_limit = EXIT_TIMEOUT_MIN;
        end else if (i_exit_timeout_setting > EXIT_TIMEOUT_MAX) begin
            exit_limit = EXIT_TIMEOUT_MAX;
        end
    end

    // armed by a run in saving, dropped on return to normal
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            exit_armed <= 1'b0;
        end else if (next_state == ST_NORMAL) begin
            exit_armed <= 1'b0;
        end else if (state == ST_SAVING && i_run_cmd) begin
            exit_armed <= 1'b1;
        end
    end

    sec_timer #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC),
        .COUNT_W        (EXIT_W)
    ) u_exit_timer (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_clear    (!exit_armed),
        .i_limit    (exit_limit),
        .o_done     (exit_done)
    );

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------

    // first cycle after reset release
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_init <= 1'b0;
        end else begin
            pwr_init <= 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_NORMAL: begin
                if (!pwr_init && entry_enabled) begin
                    next_state = ST_SAVING;
                end else if (sel_rise && i_motor_stopped && !i_run_cmd) begin
                    next_state = ST_SAVING;
                end else if (entry_done && !entry_clear) begin
                    next_state = ST_SAVING;
                end
            end
            ST_SAVING: begin
                if (i_run_cmd || sel_fall) begin
                    next_state = ST_RECHARGE;
                end
            end
            ST_RECHARGE: begin
                if (i_bus_ready) begin
                    next_state = ST_NORMAL;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // bus regulation off only while saving
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_hold     <= 1'b1;
            o_esave_active <= 1'b0;
        end else begin
            o_bus_hold     <= (next_state != ST_SAVING);
            o_esave_active <= (next_state != ST_NORMAL);
        end
    end

    // run passes only in normal operation
    assign o_run_enable = i_run_cmd && (state == ST_NORMAL);

    // sticky exit error, a new timeout beats the acknowledge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_exit_error <= 1'b0;
        end else if (exit_done && state != ST_NORMAL) begin
            o_exit_error <= 1'b1;
        end else if (i_error_ack) begin
            o_exit_error <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_run_in_saving;
        state == ST_SAVING && i_run_cmd;
    endsequence

    sequence s_recharge_wait;
        state == ST_RECHARGE && !o_run_enable;
    endsequence

    a_bus_hold_off: assert property (
        (state == ST_SAVING) |-> !o_bus_hold && o_esave_active)
        else $error("bus still held while saving");

    a_run_held_back: assert property (
        s_run_in_saving |=> s_recharge_wait)
        else $error("run passed before bus recharge");

    a_delay_entry: assert property (
        (state == ST_NORMAL && entry_done && !entry_clear) |=> state == ST_SAVING && !o_bus_hold)
        else $error("delay expiry did not enter saving");

    a_powerup_entry: assert property (
        ($rose(pwr_init) && $past(entry_enabled)) |-> state == ST_SAVING)
        else $error("power-on did not enter saving");

    a_delay_disabled: assert property (
        (!entry_enabled) |=> !entry_done)
        else $error("disabled delay timer expired");

    a_edge_entry: assert property (
        (state == ST_NORMAL && pwr_init && sel_rise && !i_motor_stopped && !entry_done)
        |=> state == ST_NORMAL)
        else $error("rising edge entered saving with motor moving");

    a_edge_exit: assert property (
        (state == ST_SAVING && sel_fall) |=> state == ST_RECHARGE ##1 o_bus_hold)
        else $error("falling edge did not leave saving");

    a_recharge_done: assert property (
        (state == ST_RECHARGE && i_bus_ready && i_run_cmd)
        |=> state == ST_NORMAL && !o_esave_active && o_run_enable == i_run_cmd)
        else $error("run not released after recharge");

    a_exit_error: assert property (
        (exit_done && state != ST_NORMAL) |=> o_exit_error)
        else $error("exit timeout did not raise error");

    a_timeout_range: assert property (
        exit_limit >= EXIT_TIMEOUT_MIN && exit_limit <= EXIT_TIMEOUT_MAX)
        else $error("exit timeout outside range");

    a_timeout_clear: assert property (
        (state == ST_NORMAL) |=> !exit_armed ##1 !exit_done)
        else $error("exit timer alive in normal operation");

    a_selector_none: assert property (
        (i_esave_src == SRC_NONE) |-> !sel_level)
        else $error("unassigned selector produced a level");

    a_edge_enter: assert property (
        (state == ST_NORMAL && sel_rise && i_motor_stopped && !i_run_cmd) |=> state == ST_SAVING && o_esave_active)
        else $error("rising edge did not enter saving");

    a_busy_refused: assert property (
        (state == ST_NORMAL && pwr_init && sel_rise && i_run_cmd) |=> state == ST_NORMAL)
        else $error("rising edge entered saving with run active");

    a_powerup_idle: assert property (
        (!pwr_init && !entry_enabled && !sel_rise) |=> state == ST_NORMAL)
        else $error("disabled delay entered saving at power-on");

    a_timeout_arm: assert property (
        s_run_in_saving |=> exit_armed)
        else $error("run in saving did not arm exit timer");

    a_error_set_wins: assert property (
        (exit_done && state != ST_NORMAL && i_error_ack) |=> o_exit_error)
        else $error("acknowledge beat a pending exit timeout");

endmodule // dc_bus_energy_saving_ctrl
`default_nettype wire

// ==== dv/drive_side_model.sv ====
// drive run logic, motor, bus charge and energy saving input source model
`timescale 1ns/1ps
`default_nettype none
module drive_side_model
    import esave_pkg::*;
(
    input  wire logic                                              i_core_clk,
    input  wire logic                                              i_run_enable,
    input  wire logic                                              i_bus_hold,
    input  wire logic                                              i_run_req,
    input  wire logic                                              i_level,
    input  wire logic [esave_pkg::SRC_W-1:0]                       i_src,
    input  wire logic [esave_pkg::BIT_W-1:0]                       i_bit,
    input  wire logic                                              i_stall,
    output logic                                                   o_motor_stopped,
    output logic                                                   o_run_cmd,
    output logic                                                   o_bus_ready,
    output logic [15:0]                                            o_dig_in,
    output logic [esave_pkg::CMD_WORDS*esave_pkg::WORD_W-1:0]      o_cmd_words
);
    import esave_pkg::*;

    int unsigned spin_down = 0;
    int unsigned charge    = 0;

    // motor turns while enabled and coasts to standstill four cycles after enable drops
    initial o_motor_stopped = 1'b1;
    always @(posedge i_core_clk) begin
        if (i_run_enable) begin
            spin_down <= 3;
            o_motor_stopped <= 1'b0;
        end else if (spin_down != 0) begin
            spin_down <= spin_down - 1;
        end else begin
            o_motor_stopped <= 1'b1;
        end
    end

    // bus recharges five cycles after holding resumes, never while stalled
    initial o_bus_ready = 1'b0;
    always @(posedge i_core_clk) begin
        charge <= i_bus_hold ? charge + 1 : 0;
        o_bus_ready <= i_bus_hold && charge >= 4 && !i_stall;
    end

    // run request and the selected input line
    assign o_run_cmd   = i_run_req;
    assign o_dig_in    = (i_src == SRC_DIGITAL) ? 16'(i_level) << i_bit : 16'h0000;
    assign o_cmd_words = (i_src >= SRC_CMD0) ? 80'(i_level) << ((i_src - SRC_CMD0) * 16 + i_bit) : '0;
endmodule // drive_side_model
`default_nettype wire

// ==== dv/dc_bus_energy_saving_ctrl_test.sv ====
// self-checking bench for the dc bus energy saving controller
`timescale 1ns/1ps
`default_nettype none
module dc_bus_energy_saving_ctrl_test;
    import esave_pkg::*;

    logic clk = 1'b0, rst_n = 1'b0, run_req = 1'b0, level = 1'b0, stall = 1'b0, ack = 1'b0;
    logic [ENTRY_W-1:0] entry = ENTRY_DELAY_DISABLED;
    logic [EXIT_W-1:0]  exit_to = EXIT_TIMEOUT_DEFAULT;
    logic [SRC_W-1:0]   src = SRC_NONE;
    logic [BIT_W-1:0]   bitn = 4'h0;
    logic motor_stopped, run_cmd, bus_ready, bus_hold, esave, run_en, err;
    logic [15:0] dig_in;
    logic [CMD_WORDS*WORD_W-1:0] cmd_words;
    int bad_count = 0;
    int n_tests = 0;

    // 100 MHz core clock
    initial forever #5 clk = ~clk;

    dc_bus_energy_saving_ctrl #(.DI_COUNT(16), .CYCLES_PER_SEC(10)) u_dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_motor_stopped(motor_stopped), .i_run_cmd(run_cmd),
        .i_bus_ready(bus_ready), .i_entry_delay_setting(entry), .i_exit_timeout_setting(exit_to),
        .i_esave_src(src), .i_esave_bit(bitn), .i_dig_in(dig_in), .i_cmd_words(cmd_words),
        .i_error_ack(ack), .o_bus_hold(bus_hold), .o_esave_active(esave), .o_run_enable(run_en),
        .o_exit_error(err));

    drive_side_model u_side (
        .i_core_clk(clk), .i_run_enable(run_en), .i_bus_hold(bus_hold), .i_run_req(run_req),
        .i_level(level), .i_src(src), .i_bit(bitn), .i_stall(stall), .o_motor_stopped(motor_stopped),
        .o_run_cmd(run_cmd), .o_bus_ready(bus_ready), .o_dig_in(dig_in), .o_cmd_words(cmd_words));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait on the saving flag or the error flag
    task automatic wait_flag(input bit use_err, input logic v, input int lim);
        int k;
        k = 0;
        while ((use_err ? err : esave) !== v && k < lim) begin
            @(negedge clk);
            k++;
        end
        chk(use_err ? err : esave, v);
        if ((use_err ? err : esave) !== v) end_of_test();
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_disabled();
        cycles(12);
        chk({bus_hold, esave, err}, 16'h0004);
        rst_n = 1'b1;
        cycles(40);
        chk(esave, 1'b0);
        $display("reset and disabled delay done");
    endtask

    task automatic t_power_on_and_run();
        rst_n = 1'b0;
        entry = 15'h0002;
        cycles(3);
        rst_n = 1'b1;
        cycles(1);
        chk({bus_hold, esave}, 16'h0001);
        run_req = 1'b1;
        cycles(1);
        chk({bus_hold, esave, run_en}, 16'h0006);
        wait_flag(1'b0, 1'b0, 12);
        chk({bus_hold, run_en}, 16'h0003);
        $display("power-on entry and run exit done");
    endtask

    task automatic t_delay_entry();
        entry = 15'h0003;
        run_req = 1'b0;
        cycles(28);
        chk(esave, 1'b0);
        wait_flag(1'b0, 1'b1, 15);
        chk(bus_hold, 1'b0);
        entry = ENTRY_DELAY_DISABLED;
        run_req = 1'b1;
        wait_flag(1'b0, 1'b0, 12);
        run_req = 1'b0;
        cycles(8);
        $display("delay entry done");
    endtask

    task automatic t_edge_sources();
        run_req = 1'b1;
        src = SRC_CMD0;
        cycles(3);
        level = 1'b1;
        cycles(5);
        chk(esave, 1'b0);
        level = 1'b0;
        run_req = 1'b0;
        cycles(8);
        for (int s = 0; s <= 6; s++) begin
            src = 3'(s);
            bitn = 4'(s + 9);
            cycles(1);
            level = 1'b1;
            if (s == 0) begin
                cycles(6);
                chk(esave, 1'b0);
            end else begin
                wait_flag(1'b0, 1'b1, 5);
                level = 1'b0;
                cycles(3);
                chk(bus_hold, 1'b1);
                wait_flag(1'b0, 1'b0, 12);
            end
            level = 1'b0;
        end
        $display("edge entry per source done");
    endtask

    task automatic t_exit_timeout();
        src = SRC_CMD0;
        exit_to = EXIT_TIMEOUT_MIN;
        level = 1'b1;
        wait_flag(1'b0, 1'b1, 5);
        stall = 1'b1;
        run_req = 1'b1;
        cycles(8);
        chk({err, run_en}, 16'h0000);
        wait_flag(1'b1, 1'b1, 8);
        chk({esave, run_en}, 16'h0002);
        // acknowledge while the timeout still stands: the error must stay
        ack = 1'b1;
        cycles(1);
        ack = 1'b0;
        chk(err, 1'b1);
        stall = 1'b0;
        wait_flag(1'b0, 1'b0, 12);
        chk(run_en, 1'b1);
        ack = 1'b1;
        cycles(1);
        ack = 1'b0;
        cycles(1);
        chk(err, 1'b0);
        level = 1'b0;
        run_req = 1'b0;
        $display("exit timeout done");
    endtask

    // main sequence
    initial begin
        t_reset_disabled();
        t_power_on_and_run();
        t_delay_entry();
        t_edge_sources();
        t_exit_timeout();
        end_of_test();
    end
endmodule // dc_bus_energy_saving_ctrl_test
`default_nettype wire
